// file: core/empi_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface empi_ctl_if;
	import empi_pkg::*;
	logic start;
	logic dram;
	logic abort;
	empi_phase_e phase;
	logic last;
	logic done;
	modport seq (input start, input dram, input abort,
		output phase, output last, output done);
	modport pins (output start, output dram, output abort,
		input phase, input last, input done);
endinterface
`default_nettype wire

// file: core/empi_pkg.sv
package empi_pkg;
	// ==========================================================
	// widths and bit positions
	localparam int ADDR_W = 22;
	localparam int LOW_W = 15;
	localparam int DRAM_W = 11;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int CNT_W = 4;
	localparam int BIT15 = 15;
	localparam int BIT16 = 16;
	localparam int BIT17 = 17;
	localparam logic [DATA_W-1:0] OE_NONE = 8'h00;
	localparam logic [DATA_W-1:0] OE_FULL = 8'hFF;
	localparam logic [DATA_W-1:0] OE_NIBBLE = 8'h0F;
	localparam logic [LOW_W-1:0] ADDR_LOW_RST = 15'h7FFF;
	localparam logic [3:0] CS_IDLE = 4'hF;
	localparam logic [3:0] CS_ONE = 4'h1;

	// ==========================================================
	// timing, in ns and derived clock cycles at 200 MHz
	localparam int CLK_NS = 5;
	localparam int SETUP_NS = 5;
	localparam int ROW_NS = 10;
	localparam int STROBE_NS = 20;
	localparam int HOLD_NS = 5;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROW_CYC = (ROW_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// access phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_ADDR = 3'b001,
		PH_ROW = 3'b010,
		PH_COL = 3'b011,
		PH_STROBE = 3'b100,
		PH_HOLD = 3'b101
	} empi_phase_e;
endpackage

// file: core/empi_seq.sv
`timescale 1ns/1ps
`default_nettype none
module empi_seq #(
	parameter int SETUP = empi_pkg::SETUP_CYC,
	parameter int ROW = empi_pkg::ROW_CYC,
	parameter int STROBE = empi_pkg::STROBE_CYC,
	parameter int HOLD = empi_pkg::HOLD_CYC
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, active low
	empi_ctl_if.seq ctl // phase control
);
	import empi_pkg::*;

	empi_phase_e phase_q;
	logic [CNT_W-1:0] cnt_q;
	logic done_q;

	function automatic logic [CNT_W-1:0] len(input int n);
		len = CNT_W'(n - 1);
	endfunction

	// ==========================================================
	// phase sequence: sram addr/strobe/hold, dram row/col/hold
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= PH_IDLE;
			cnt_q <= '0;
		end else if (ctl.abort) begin
			phase_q <= PH_IDLE;
			cnt_q <= '0;
		end else if (phase_q != PH_IDLE && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			case (phase_q)
			PH_IDLE: begin
				if (ctl.start && ctl.dram) begin
					phase_q <= PH_ROW;
					cnt_q <= len(ROW);
				end else if (ctl.start) begin
					phase_q <= PH_ADDR;
					cnt_q <= len(SETUP);
				end
			end
			PH_ADDR: begin
				phase_q <= PH_STROBE;
				cnt_q <= len(STROBE);
			end
			PH_ROW: begin
				phase_q <= PH_COL;
				cnt_q <= len(STROBE);
			end
			PH_COL, PH_STROBE: begin
				phase_q <= PH_HOLD;
				cnt_q <= len(HOLD);
			end
			PH_HOLD: begin
				phase_q <= PH_IDLE;
			end
			default: begin
				phase_q <= PH_IDLE;
				cnt_q <= '0;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= !ctl.abort && phase_q == PH_HOLD && cnt_q == '0;
		end
	end

	assign ctl.phase = phase_q;
	assign ctl.last = (cnt_q == '0);
	assign ctl.done = done_q;
endmodule
`default_nettype wire

// file: core/empi_top.sv
`timescale 1ns/1ps
`default_nettype none
module empi_top (
	input wire logic CLK_SYS, // 200 MHz system clock
	input wire logic ARST_N, // hardware reset, active low
	input wire logic SW_RESET, // software reset, level
	input wire logic INDIV_RESET, // individual reset, level
	input wire logic STOP_MODE, // stop mode, level
	input wire logic CFG_NARROW, // four-bit data bus
	input wire logic CFG_CS_MODE, // upper lines act as chip selects
	input wire logic CFG_DRAM_EN, // lines 16/17 idle as dram strobes
	input wire logic CFG_REFRESH_EN, // dram refresh enabled
	input wire logic REQ_VALID, // access request
	input wire logic REQ_WRITE, // 1 write, 0 read
	input wire logic REQ_DRAM, // 1 dram, 0 sram
	input wire logic [empi_pkg::ADDR_W-1:0] REQ_ADDR, // access address
	input wire logic [empi_pkg::DATA_W-1:0] REQ_WDATA, // write data
	output logic REQ_READY, // request taken when high with valid
	output logic RSP_VALID, // access finished, one cycle
	output logic [empi_pkg::DATA_W-1:0] RSP_RDATA, // read data
	output logic [empi_pkg::LOW_W-1:0] MEM_ADDR_LOW, // address 0..14
	output logic MEM_ADDR_BIT15, // addr 15 / select 3
	output logic MEM_ADDR_BIT16, // addr 16 / select 2 / column strobe
	output logic MEM_ADDR_BIT17, // addr 17 / select 1 / row strobe
	output logic SRAM_SELECT_0_N, // sram select 0
	output logic MEM_WRITE_STROBE_N, // write strobe
	output logic MEM_READ_STROBE_N, // read strobe
	output logic [empi_pkg::DATA_W-1:0] MEM_DATA_BUS_O, // data out
	output logic [empi_pkg::DATA_W-1:0] MEM_DATA_BUS_OE, // data drive
	input wire logic [empi_pkg::DATA_W-1:0] MEM_DATA_BUS_I // data pins
);
	import empi_pkg::*;

	empi_ctl_if ctl ();

	logic [ADDR_W-1:0] addr_q;
	logic write_q;
	logic dram_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] din_meta_q;
	logic [DATA_W-1:0] din_sync_q;
	logic halt;
	logic accept;
	logic [3:0] cs_n;
	logic [DATA_W-1:0] oe_mask;

	// active-low selects 3..0; in plain mode select 0 covers all
	function automatic logic [3:0] cs_decode(input logic [1:0] hi,
		input logic cs_mode);
		if (cs_mode) begin
			cs_decode = ~(CS_ONE << hi);
		end else begin
			cs_decode = ~CS_ONE;
		end
	endfunction

	assign halt = SW_RESET | INDIV_RESET | STOP_MODE;
	assign accept = REQ_VALID & REQ_READY;
	assign cs_n = cs_decode(addr_q[BIT17:BIT16], CFG_CS_MODE);
	assign oe_mask = CFG_NARROW ? OE_NIBBLE : OE_FULL;
	assign ctl.start = accept;
	assign ctl.dram = REQ_DRAM;
	assign ctl.abort = halt;

	empi_seq u_seq (
		.clk(CLK_SYS),
		.arst_n(ARST_N),
		.ctl(ctl)
	);

	// ==========================================================
	// request capture and handshake
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			addr_q <= '0;
			write_q <= 1'b0;
			dram_q <= 1'b0;
			wdata_q <= '0;
		end else if (accept) begin
			addr_q <= REQ_ADDR;
			write_q <= REQ_WRITE;
			dram_q <= REQ_DRAM;
			wdata_q <= REQ_WDATA;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			REQ_READY <= 1'b0;
			RSP_VALID <= 1'b0;
		end else begin
			REQ_READY <= !halt && !accept && ctl.phase == PH_IDLE;
			RSP_VALID <= ctl.done;
		end
	end

	// ==========================================================
	// read data: pins pass two flops, captured at end of strobe
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			din_meta_q <= '0;
			din_sync_q <= '0;
			RSP_RDATA <= '0;
		end else begin
			din_meta_q <= MEM_DATA_BUS_I;
			din_sync_q <= din_meta_q;
			if (!write_q && ctl.last && (ctl.phase == PH_STROBE ||
				ctl.phase == PH_COL)) begin
				RSP_RDATA <= din_sync_q & oe_mask;
			end
		end
	end

	// ==========================================================
	// address and shared upper pins
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			MEM_ADDR_LOW <= ADDR_LOW_RST;
			MEM_ADDR_BIT15 <= 1'b1;
			MEM_ADDR_BIT16 <= 1'b1;
			MEM_ADDR_BIT17 <= 1'b1;
		end else if (SW_RESET) begin
			MEM_ADDR_BIT15 <= 1'b1;
			MEM_ADDR_BIT16 <= 1'b1;
			MEM_ADDR_BIT17 <= 1'b1;
		end else if (halt || ctl.phase == PH_IDLE) begin
			// low lines hold; selects and strobes go inactive, except refresh in individual reset pulls dram strobes 16/17 low
			if (CFG_CS_MODE) begin
				MEM_ADDR_BIT15 <= 1'b1;
			end
			if (CFG_DRAM_EN) begin
				MEM_ADDR_BIT16 <= !(INDIV_RESET && CFG_REFRESH_EN);
				MEM_ADDR_BIT17 <= !(INDIV_RESET && CFG_REFRESH_EN);
			end else if (CFG_CS_MODE) begin
				MEM_ADDR_BIT16 <= 1'b1;
				MEM_ADDR_BIT17 <= 1'b1;
			end
		end else if (dram_q) begin
			case (ctl.phase)
			PH_ROW: begin
				MEM_ADDR_LOW[DRAM_W-1:0] <= addr_q[2*DRAM_W-1:DRAM_W];
				MEM_ADDR_BIT17 <= 1'b0;
				MEM_ADDR_BIT16 <= 1'b1;
			end
			PH_COL: begin
				MEM_ADDR_LOW[DRAM_W-1:0] <= addr_q[DRAM_W-1:0];
				MEM_ADDR_BIT17 <= 1'b0;
				MEM_ADDR_BIT16 <= 1'b0;
			end
			default: begin
				MEM_ADDR_BIT17 <= 1'b1;
				MEM_ADDR_BIT16 <= 1'b1;
			end
			endcase
		end else begin
			MEM_ADDR_LOW <= addr_q[LOW_W-1:0];
			if (CFG_CS_MODE) begin
				MEM_ADDR_BIT15 <= cs_n[3];
				MEM_ADDR_BIT16 <= cs_n[2];
				MEM_ADDR_BIT17 <= cs_n[1];
			end else begin
				MEM_ADDR_BIT15 <= addr_q[BIT15];
				MEM_ADDR_BIT16 <= addr_q[BIT16];
				MEM_ADDR_BIT17 <= addr_q[BIT17];
			end
		end
	end

	// ==========================================================
	// select 0 and read/write strobes
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			SRAM_SELECT_0_N <= 1'b1;
			MEM_WRITE_STROBE_N <= 1'b1;
			MEM_READ_STROBE_N <= 1'b1;
		end else if (halt || ctl.phase == PH_IDLE) begin
			SRAM_SELECT_0_N <= 1'b1;
			MEM_WRITE_STROBE_N <= 1'b1;
			MEM_READ_STROBE_N <= 1'b1;
		end else begin
			SRAM_SELECT_0_N <= dram_q | cs_n[0];
			MEM_WRITE_STROBE_N <= !(write_q && (ctl.phase == PH_STROBE ||
				ctl.phase == PH_COL));
			MEM_READ_STROBE_N <= !(!write_q && (ctl.phase == PH_STROBE ||
				ctl.phase == PH_COL));
		end
	end

	// ==========================================================
	// data drive: only while a write is under way
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			MEM_DATA_BUS_O <= '0;
			MEM_DATA_BUS_OE <= OE_NONE;
		end else if (halt || ctl.phase == PH_IDLE || !write_q) begin
			MEM_DATA_BUS_OE <= OE_NONE;
		end else begin
			MEM_DATA_BUS_O <= wdata_q & oe_mask;
			MEM_DATA_BUS_OE <= oe_mask;
		end
	end
endmodule
`default_nettype wire

// file: tb/empi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module empi_mem_model (
	input wire logic rd_n, // read strobe
	input wire logic wr_n, // write strobe
	input wire logic [7:0] key, // word index
	input wire logic [7:0] bus, // resolved data pins
	output logic [7:0] drv // level offered to pins
);
	logic [7:0] mem [256];
	logic [7:0] idle = 8'h5A;
	// ==========
	// storage
	always @(posedge wr_n) mem[key] <= bus;
	// released pins flip so no stale value passes for data
	always @(posedge rd_n) idle <= ~idle;
	// memory drives only while the read strobe is low
	assign drv = rd_n ? idle : mem[key];
endmodule
`default_nettype wire

// file: tb/empi_tb.sv
`timescale 1ns/1ps
`default_nettype none
module empi_tb;
	import empi_pkg::*;
	logic clk, rn, swr, ivr, stp, nar, csm, den, rfe, rv, rw, rd, rdy, rsv;
	logic a15, a16, a17, cs0, wrn, rdn;
	logic [21:0] ra;
	logic [14:0] al, p;
	logic [7:0] wd, rdat, dout, doe, din, mdrv;
	logic [7:0] shadow [256];
	int error_cnt, check_count, cyc;
	empi_top dut (.CLK_SYS(clk), .ARST_N(rn), .SW_RESET(swr),
		.INDIV_RESET(ivr), .STOP_MODE(stp), .CFG_NARROW(nar),
		.CFG_CS_MODE(csm), .CFG_DRAM_EN(den), .CFG_REFRESH_EN(rfe),
		.REQ_VALID(rv), .REQ_WRITE(rw), .REQ_DRAM(rd), .REQ_ADDR(ra),
		.REQ_WDATA(wd), .REQ_READY(rdy), .RSP_VALID(rsv),
		.RSP_RDATA(rdat), .MEM_ADDR_LOW(al), .MEM_ADDR_BIT15(a15),
		.MEM_ADDR_BIT16(a16), .MEM_ADDR_BIT17(a17),
		.SRAM_SELECT_0_N(cs0), .MEM_WRITE_STROBE_N(wrn),
		.MEM_READ_STROBE_N(rdn), .MEM_DATA_BUS_O(dout),
		.MEM_DATA_BUS_OE(doe), .MEM_DATA_BUS_I(din));
	empi_mem_model u_mem (.rd_n(rdn), .wr_n(wrn), .key(al[7:0]),
		.bus(din), .drv(mdrv));
	assign din = (doe & dout) | (~doe & mdrv);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	// ==========
	// helpers
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	function automatic logic [7:0] expd(input logic [21:0] a);
		return shadow[a[7:0]] & (nar ? OE_NIBBLE : OE_FULL);
	endfunction
	task automatic acc(input logic w, d, input logic [21:0] a,
		input logic [7:0] v);
		int n;
		logic sw, sr, pb, ok;
		n = 0;
		sw = 0;
		sr = 0;
		pb = 0;
		@(negedge clk);
		{rv, rw, rd, ra, wd} = {1'b1, w, d, a, v};
		while (rdy !== 1'b1 && n++ < 50) @(negedge clk);
		@(negedge clk);
		rv = 0;
		while (rsv !== 1'b1 && n++ < 90) begin
			@(negedge clk);
			sw |= !wrn;
			sr |= !rdn;
			if (d)
				ok = al[10:0] == (a16 ? a[21:11] : a[10:0]);
			else if (csm)
				ok = al == a[14:0] && {a15, a16, a17, cs0} == ~(4'h1 << a[17:16]);
			else
				ok = al == a[14:0] && {cs0, a17, a16, a15} == {1'b0, a[17:15]};
			if (d ? !a17 : (!wrn || !rdn))
				pb |= ok !== 1'b1;
		end
		chk(rsv, "no response");
		chk(w ? sw && !sr : sr && !sw, "strobe");
		chk(!pb, "address pins");
		if (w)
			shadow[a[7:0]] = v;
		else
			chk(rdat === expd(a), "read data");
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		logic [21:0] a;
		logic q15, hit;
		clk = 0;
		{rn, swr, ivr, stp, nar, csm, den, rfe, rv, rw, rd} = '0;
		{ra, wd} = '0;
		void'($urandom(60));
		repeat (16) @(negedge clk);
		rn = 1;
		// modes: plain, narrow, select decode, dram
		for (int m = 0; m < 4; m++) begin
			{nar, csm, den} = {m == 1, m == 2, m == 3};
			for (int j = 0; j < 6; j++) begin
				a = j == 0 ? '0 : j == 1 ? '1 : 22'($urandom);
				if (m == 2)
					a[17:16] = j[1:0];
				acc(1, m == 3, a, 8'($urandom));
				acc(0, m == 3, a, 8'h00);
			end
		end
		// software, individual, stop with refresh on
		rfe = 1;
		// second pass with select decode: line 15 is then select 3
		for (int k = 0; k < 6; k++) begin
			p = al;
			q15 = a15;
			csm = k > 2;
			{swr, ivr, stp} = {k % 3 == 0, k % 3 == 1, k % 3 == 2};
			repeat (3) @(negedge clk);
			chk({a16, a17} === (k % 3 == 1 ? 2'b00 : 2'b11) && al === p
				&& a15 === (k % 3 == 0 || csm ? 1'b1 : q15),
				"halt pins");
			chk({cs0, wrn, rdn} === 3'b111 && doe === OE_NONE,
				"halt strobes");
			{swr, ivr, stp} = '0;
			repeat (2) @(negedge clk);
		end
		// a write cut short by stop mode: no response, pins released
		hit = 0;
		{rv, rw, rd, ra, wd} = {1'b1, 1'b1, 1'b0, 22'h00077, 8'h3C};
		@(negedge clk);
		rv = 0;
		repeat (2) @(negedge clk) hit |= rsv;
		stp = 1;
		repeat (3) @(negedge clk) hit |= rsv;
		chk({cs0, wrn, rdn} === 3'b111 && doe === OE_NONE && rdy === 1'b0,
			"abort pins");
		stp = 0;
		repeat (10) @(negedge clk) hit |= rsv;
		chk(hit === 1'b0 && rdy === 1'b1, "aborted access");
		acc(1, 1, 22'h2A5C3, 8'h96);
		rn = 0;
		@(negedge clk);
		chk(al === ADDR_LOW_RST && {a15, a16, a17, cs0, wrn, rdn} === 6'h3F
			&& doe === OE_NONE, "hw reset pins");
		repeat (16) @(negedge clk);
		rn = 1;
		acc(1, 0, 22'h01234, 8'hC3);
		acc(0, 0, 22'h01234, 8'h00);
		end_sim();
	end
endmodule
bind empi_top empi_top_monitor u_mon (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
	.SW_RESET(SW_RESET), .INDIV_RESET(INDIV_RESET),
	.STOP_MODE(STOP_MODE), .CFG_NARROW(CFG_NARROW),
	.CFG_DRAM_EN(CFG_DRAM_EN), .CFG_REFRESH_EN(CFG_REFRESH_EN),
	.RSP_VALID(RSP_VALID), .MEM_ADDR_LOW(MEM_ADDR_LOW),
	.MEM_ADDR_BIT15(MEM_ADDR_BIT15), .MEM_ADDR_BIT16(MEM_ADDR_BIT16),
	.MEM_ADDR_BIT17(MEM_ADDR_BIT17), .SRAM_SELECT_0_N(SRAM_SELECT_0_N),
	.MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N),
	.MEM_READ_STROBE_N(MEM_READ_STROBE_N),
	.MEM_DATA_BUS_OE(MEM_DATA_BUS_OE));
`default_nettype wire

// file: tb/empi_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module empi_top_monitor (
	input wire logic CLK_SYS, // clock
	input wire logic ARST_N, // reset
	input wire logic SW_RESET, // sw reset
	input wire logic INDIV_RESET, // indiv reset
	input wire logic STOP_MODE, // stop
	input wire logic CFG_NARROW, // narrow bus
	input wire logic CFG_DRAM_EN, // dram strobes
	input wire logic CFG_REFRESH_EN, // refresh
	input wire logic RSP_VALID, // done pulse
	input wire logic [empi_pkg::LOW_W-1:0] MEM_ADDR_LOW, // low address
	input wire logic MEM_ADDR_BIT15, // line 15
	input wire logic MEM_ADDR_BIT16, // line 16
	input wire logic MEM_ADDR_BIT17, // line 17
	input wire logic SRAM_SELECT_0_N, // select 0
	input wire logic MEM_WRITE_STROBE_N, // write strobe
	input wire logic MEM_READ_STROBE_N, // read strobe
	input wire logic [empi_pkg::DATA_W-1:0] MEM_DATA_BUS_OE // drive
);
	import empi_pkg::*;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);
	// ==========
	// sequences
	sequence s_halt;
		(SW_RESET || INDIV_RESET || STOP_MODE) [*2];
	endsequence
	sequence s_rd_low;
		(!MEM_READ_STROBE_N && MEM_DATA_BUS_OE == OE_NONE) [*4]
			##1 MEM_READ_STROBE_N;
	endsequence
	// ==========
	// properties
	property p_hw_rst;
		$rose(ARST_N) |-> MEM_ADDR_LOW == ADDR_LOW_RST && MEM_ADDR_BIT15;
	endproperty
	property p_sw;
		SW_RESET [*2] |-> MEM_ADDR_BIT15 && MEM_ADDR_BIT16
			&& MEM_ADDR_BIT17 && $stable(MEM_ADDR_LOW);
	endproperty
	property p_halt;
		s_halt |-> SRAM_SELECT_0_N && MEM_WRITE_STROBE_N
			&& MEM_READ_STROBE_N && MEM_DATA_BUS_OE == OE_NONE;
	endproperty
	property p_refresh;
		(INDIV_RESET && !SW_RESET && CFG_DRAM_EN && CFG_REFRESH_EN) [*2]
			|-> !MEM_ADDR_BIT16 && !MEM_ADDR_BIT17;
	endproperty
	property p_stop;
		(STOP_MODE && !SW_RESET && !INDIV_RESET && CFG_DRAM_EN) [*2]
			|-> MEM_ADDR_BIT16 && MEM_ADDR_BIT17;
	endproperty
	property p_rd;
		$fell(MEM_READ_STROBE_N) |-> s_rd_low;
	endproperty
	property p_wr;
		!MEM_WRITE_STROBE_N
			|-> MEM_DATA_BUS_OE == (CFG_NARROW ? OE_NIBBLE : OE_FULL);
	endproperty
	property p_rsp;
		RSP_VALID |=> !RSP_VALID;
	endproperty
	property p_dram;
		// select 0 stays high in dram accesses, idle, and select-decode accesses to selects 1..3
		$fell(MEM_ADDR_BIT17) && CFG_DRAM_EN && !INDIV_RESET
			&& SRAM_SELECT_0_N
			|-> MEM_ADDR_BIT16 ##2 !MEM_ADDR_BIT16;
	endproperty
	a_hw_rst: assert property (p_hw_rst)
		else $error("hw reset pins");
	a_sw: assert property (p_sw)
		else $error("sw reset pins");
	a_halt: assert property (p_halt)
		else $error("halt strobes");
	a_refresh: assert property (p_refresh)
		else $error("refresh strobes");
	a_stop: assert property (p_stop)
		else $error("stop strobes");
	a_rd: assert property (p_rd)
		else $error("read strobe");
	a_wr: assert property (p_wr)
		else $error("write drive");
	a_rsp: assert property (p_rsp)
		else $error("response pulse");
	a_dram: assert property (p_dram)
		else $error("row then column");
endmodule
`default_nettype wire
